// ### iac_pkg.sv
package iac_pkg;

	// Register offsets on the plain register port (byte addresses).
	localparam logic [7:0] OFF_ENABLE   = 8'h00;
	localparam logic [7:0] OFF_FLAG     = 8'h04;
	localparam logic [7:0] OFF_LEVEL    = 8'h08;
	localparam logic [7:0] OFF_MODE     = 8'h0c;
	localparam logic [7:0] OFF_EVT_STAT = 8'h10;
	localparam logic [7:0] OFF_EVT_MASK = 8'h14;
	localparam logic [7:0] OFF_LAST_ACC = 8'h18;

	// Values after reset.
	localparam logic [31:0] RST_ENABLE   = 32'h0000_0000;
	localparam logic [31:0] RST_LEVEL    = 32'h0000_0000;
	localparam logic [1:0]  RST_MODE     = 2'h0;
	localparam logic [3:0]  RST_EVT_MASK = 4'h0;

	// Mode register field positions.
	localparam int MODE_MASK0_POS = 0;
	localparam int MODE_MASK1_POS = 1;

	// Event status bit positions.
	localparam int EVT_W          = 4;
	localparam int EVT_ACCEPT     = 0;
	localparam int EVT_NMI_BREAK  = 1;
	localparam int EVT_DISCARD    = 2;
	localparam int EVT_DEFER      = 3;

	// Vector numbering: fixed sources first, peripherals follow.
	localparam int         VEC_W      = 6;
	localparam logic [5:0] VEC_NMI    = 6'h00;
	localparam logic [5:0] VEC_ABRK   = 6'h01;
	localparam logic [5:0] VEC_PERIPH = 6'h02;

	// Each peripheral source carries a two-bit mask level.
	localparam int LEVEL_W = 2;
	localparam int PC_W    = 16;

	// Class of the instruction that the core reports at its end.
	typedef enum logic [2:0] {
		IAC_INSN_PLAIN    = 3'b000,
		IAC_INSN_MASK_CHG = 3'b001,
		IAC_INSN_BLK_BYTE = 3'b010,
		IAC_INSN_BLK_WORD = 3'b011
	} iac_insn_t;

	// Acceptance sequencing states.
	typedef enum logic [1:0] {
		IAC_ST_IDLE  = 2'b00,
		IAC_ST_STACK = 2'b01
	} iac_state_t;

	// Status that the core hands to the block every cycle.
	typedef struct packed {
		logic            insn_end;
		iac_insn_t       insn_cls;
		logic            blk_word_busy;
		logic            blk_byte_busy;
		logic            xfer_break;
		logic            stack_done;
		logic            ccr_mask;
		logic [PC_W-1:0] next_pc;
	} iac_core_t;

	// Acceptance handed to the core.
	typedef struct packed {
		logic             valid;
		logic             is_nmi;
		logic             ret_next;
		logic [VEC_W-1:0] vector;
		logic [PC_W-1:0]  ret_pc;
	} iac_accept_t;

endpackage : iac_pkg

// ### iac_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves only once stages two and three agree.
module iac_sync3 (
	input  wire logic i_sys_clk,
	input  wire logic i_nrst,
	input  wire logic i_async,
	output logic      o_level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// The first stage feeds only the second, so metastability stays contained.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				o_level <= s3_reg;
			end
		end
	end
endmodule : iac_sync3

// ### iac_prio.sv
`timescale 1ns/1ps
// Fixed priority picker: the lowest set index wins.
module iac_prio #(
	parameter int W = 8
) (
	input  wire logic [W-1:0]         i_req,
	output logic                      o_found,
	output logic [$clog2(W+1)-1:0]    o_idx,
	output logic [W-1:0]              o_onehot
);
	// Scan from the top so that the lowest index is written last.
	always_comb begin
		o_found  = 1'b0;
		o_idx    = '0;
		o_onehot = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (i_req[i]) begin
				o_found  = 1'b1;
				o_idx    = i[$clog2(W+1)-1:0];
				o_onehot = '0;
				o_onehot[i] = 1'b1;
			end
		end
	end
endmodule : iac_prio

// ### iac_top.sv
`timescale 1ns/1ps
// Function
// - Clearing an enable bit takes effect only after the clearing instruction ends, so a request raised during it is still taken.
// - If a higher-priority request is pending at that boundary, it is served and the racing lower one is dropped.
// - Clearing a source flag to zero behaves the same way as clearing its enable bit.
// - A clear done while the request is masked causes no race and no exception handling.
// - After a mask-changing instruction the next instruction always runs before a pending interrupt is taken.
// - The mask level of a new request is resolved before the request is forwarded to the core.
// - During a byte-count block move nothing, not even the non-maskable request, is accepted until the move ends.
// - During a word-count block move every maskable request waits until the move ends.
// - A non-maskable request during a word-count block move is taken at a break between transfer cycles.
// - When a word-count block move is broken that way, the saved return address is that of the next instruction.
// - A clear done with the global mask bit at zero that meets a request still yields exception handling afterwards.
// - With the global mask bit set, all requests except the non-maskable one and the address break wait.
// - An accepted request starts exception handling only once the current instruction has completed, except a non-maskable break inside a word-count block move.
// - After the core stacks the program counter and condition code, the global mask bit is set.
module iac_top
	import iac_pkg::*;
#(
	parameter int NUM_SRC = 8
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_nrst,
	input  wire logic [7:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [31:0]        o_rdata,
	input  wire logic [NUM_SRC-1:0] i_src_raise,
	input  wire logic               i_nmi_pin,
	input  wire logic               i_abrk_req,
	input  wire iac_core_t          i_core,
	output iac_accept_t             o_accept,
	output logic      [NUM_SRC-1:0] o_req_fwd,
	output logic                    o_set_mask,
	output logic                    o_irq
);
	localparam int IDX_W = $clog2(NUM_SRC + 1);

	// The level field packs two bits per source into one 32-bit word.
	if (NUM_SRC < 1 || NUM_SRC > 16) begin : g_bad_num_src
		$error("NUM_SRC must lie between 1 and 16");
	end

	// Committed state used for acceptance, and the software view written now.
	// Keeping two copies is what lets a clear lose a race against a request raised in
	// the same instruction, at the cost of a second register per enable bit.
	logic [NUM_SRC-1:0]         en_reg;
	logic [NUM_SRC-1:0]         en_shadow_reg;
	logic [NUM_SRC-1:0]         en_shadow_next;
	logic [NUM_SRC-1:0]         flag_reg;
	logic [NUM_SRC-1:0]         flag_next;
	logic [NUM_SRC-1:0]         clr_pend_reg;
	logic [NUM_SRC-1:0]         clr_pend_next;
	logic [2*NUM_SRC-1:0]       level_reg;
	logic [1:0]                 mode_reg;
	logic [NUM_SRC-1:0]         pend_reg;
	logic                       nmi_pend_reg;
	logic                       abrk_pend_reg;
	logic                       nmi_seen_reg;
	iac_state_t                 state_reg;
	iac_state_t                 state_next;
	logic [EVT_W-1:0]           evt_stat_reg;
	logic [EVT_W-1:0]           evt_mask_reg;
	logic [VEC_W-1:0]           last_vec_reg;

	// Register port decode.
	// The port never stalls, so every hit is a plain compare against the package offsets.
	// An address that hits nothing ignores writes and reads back as zero.
	wire hit_enable = (i_addr == OFF_ENABLE);
	wire hit_flag   = (i_addr == OFF_FLAG);
	wire hit_level  = (i_addr == OFF_LEVEL);
	wire hit_mode   = (i_addr == OFF_MODE);
	wire hit_stat   = (i_addr == OFF_EVT_STAT);
	wire hit_mask   = (i_addr == OFF_EVT_MASK);
	wire hit_last   = (i_addr == OFF_LAST_ACC);
	wire wr_enable  = i_wr && hit_enable;
	wire wr_flag    = i_wr && hit_flag;
	wire rd_stat    = i_rd && hit_stat;

	// Synchronised non-maskable pin; a rising edge latches a request.
	// The pin is asynchronous and passes four flops, which costs a few cycles of latency
	// that the same-clock sources never pay.
	wire nmi_level;
	iac_sync3 u_nmi_sync (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_async   (i_nmi_pin),
		.o_level   (nmi_level)
	);
	wire nmi_rise = nmi_level && !nmi_seen_reg;

	// Software writes gather here and reach the committed copies only at the boundary.
	// A write in the very cycle of the instruction end still counts toward that end.
	// Flag clears are remembered as a pending mask, since a clear must not erase a raise
	// that arrives while the clearing instruction is still running.
	wire [NUM_SRC-1:0] flag_wr_clr = wr_flag ? ~i_wdata[NUM_SRC-1:0] : '0;
	assign en_shadow_next = wr_enable ? i_wdata[NUM_SRC-1:0] : en_shadow_reg;
	assign clr_pend_next  = i_core.insn_end ? '0 : (clr_pend_reg | flag_wr_clr);
	wire [NUM_SRC-1:0] clr_commit = clr_pend_reg | flag_wr_clr;

	// Mask level resolution per source.
	// The higher mode bit wins when both are set, matching the stricter of the two levels.
	// Only peripheral sources carry a level; the fixed sources bypass this stage.
	logic [NUM_SRC-1:0] level_ok;
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			if (mode_reg[MODE_MASK1_POS]) begin
				level_ok[i] = (level_reg[2*i +: 2] > 2'h1);
			end else if (mode_reg[MODE_MASK0_POS]) begin
				level_ok[i] = (level_reg[2*i +: 2] > 2'h0);
			end else begin
				level_ok[i] = 1'b1;
			end
		end
	end

	// A global mask bit holds every peripheral request but not the two fixed ones.
	// A held request keeps its flag, so it is taken once the mask bit falls again.
	// The resolved word is registered before use, which spends one cycle per new request.
	wire [NUM_SRC-1:0] resolved = (flag_reg & en_reg & level_ok) & {NUM_SRC{!i_core.ccr_mask}};

	// Candidates use the committed copies, which still carry the pre-write values.
	// The global mask is read live here, so a masked core takes no peripheral request at this boundary
	// and a clear done under the mask never turns into a race.
	wire [NUM_SRC-1:0] cand = pend_reg & flag_reg & en_reg & {NUM_SRC{!i_core.ccr_mask}};

	wire               prio_found;
	wire [IDX_W-1:0]   prio_idx;
	wire [NUM_SRC-1:0] prio_onehot;
	iac_prio #(
		.W (NUM_SRC)
	) u_prio (
		.i_req    (cand),
		.o_found  (prio_found),
		.o_idx    (prio_idx),
		.o_onehot (prio_onehot)
	);

	// Acceptance decisions.
	// A word move may be broken only by the non-maskable request, and only at a break
	// between transfers; every other request waits for an instruction end.
	// The fixed priority is non-maskable, then address break, then peripherals.
	wire idle         = (state_reg == IAC_ST_IDLE);
	wire boundary     = i_core.insn_end && idle;
	// The class reported with the instruction end tells whether the mask just changed.
	// The hold-off covers the non-maskable request too, so the next instruction always runs.
	wire defer_now    = (i_core.insn_cls == IAC_INSN_MASK_CHG);
	wire any_pending  = nmi_pend_reg || abrk_pend_reg || prio_found;
	wire take_nmi_brk = idle && nmi_pend_reg && i_core.blk_word_busy && i_core.xfer_break;
	wire take_bound   = boundary && !defer_now && any_pending && !take_nmi_brk;
	wire take_any     = take_nmi_brk || take_bound;
	wire take_nmi     = take_nmi_brk || (take_bound && nmi_pend_reg);
	wire take_abrk    = take_bound && !nmi_pend_reg && abrk_pend_reg;
	wire take_periph  = take_bound && !nmi_pend_reg && !abrk_pend_reg;

	// Racing sources: being disabled or cleared now and not the winner.
	// A loser is dropped rather than queued: its enable or flag is already gone once this
	// boundary passes, so only the discard event records that it ever raced.
	wire [NUM_SRC-1:0] racing = cand & ((en_reg & ~en_shadow_next) | clr_commit);
	wire [NUM_SRC-1:0] lost   = take_periph ? (racing & ~prio_onehot) : (take_bound ? racing : '0);

	logic [VEC_W-1:0] take_vec;
	always_comb begin
		if (take_nmi) begin
			take_vec = VEC_NMI;
		end else if (take_abrk) begin
			take_vec = VEC_ABRK;
		end else begin
			take_vec = VEC_PERIPH + VEC_W'(prio_idx);
		end
	end

	// Events that latch into the status register.
	logic [EVT_W-1:0] evt_set;
	always_comb begin
		evt_set                = '0;
		evt_set[EVT_ACCEPT]    = take_any;
		evt_set[EVT_NMI_BREAK] = take_nmi_brk;
		evt_set[EVT_DISCARD]   = |lost;
		evt_set[EVT_DEFER]     = boundary && defer_now && any_pending;
	end

	// Next flag value: a raise in the clearing cycle wins over the clear.
	// Clears land only at an instruction end; at any other cycle the flag just collects raises.
	// Acceptance itself never clears a flag, which is left to the handler.
	assign flag_next = (i_core.insn_end ? (flag_reg & ~clr_commit) : flag_reg) | i_src_raise;

	// Acceptance sequencing.
	// The stacking state blocks a second accept until the core reports the stack written.
	always_comb begin
		case (state_reg)
			IAC_ST_IDLE: begin
				state_next = take_any ? IAC_ST_STACK : IAC_ST_IDLE;
			end
			IAC_ST_STACK: begin
				state_next = i_core.stack_done ? IAC_ST_IDLE : IAC_ST_STACK;
			end
			default: begin
				state_next = IAC_ST_IDLE;
			end
		endcase
	end

	// Read data mux.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_enable) begin
			rd_mux[NUM_SRC-1:0] = en_shadow_reg;
		end else if (hit_flag) begin
			rd_mux[NUM_SRC-1:0] = flag_reg & ~clr_pend_reg;
		end else if (hit_level) begin
			rd_mux[2*NUM_SRC-1:0] = level_reg;
		end else if (hit_mode) begin
			rd_mux[1:0] = mode_reg;
		end else if (hit_stat) begin
			rd_mux[EVT_W-1:0] = evt_stat_reg;
		end else if (hit_mask) begin
			rd_mux[EVT_W-1:0] = evt_mask_reg;
		end else if (hit_last) begin
			rd_mux[VEC_W-1:0] = last_vec_reg;
		end
	end

	// Software-visible configuration.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			en_shadow_reg <= RST_ENABLE[NUM_SRC-1:0];
			level_reg     <= RST_LEVEL[2*NUM_SRC-1:0];
			mode_reg      <= RST_MODE;
			evt_mask_reg  <= RST_EVT_MASK;
			clr_pend_reg  <= '0;
		end else begin
			en_shadow_reg <= en_shadow_next;
			clr_pend_reg  <= clr_pend_next;
			if (i_wr && hit_level) begin
				level_reg <= i_wdata[2*NUM_SRC-1:0];
			end
			if (i_wr && hit_mode) begin
				mode_reg <= i_wdata[1:0];
			end
			if (i_wr && hit_mask) begin
				evt_mask_reg <= i_wdata[EVT_W-1:0];
			end
		end
	end

	// Committed enables move only at the instruction end; flags collect raises every cycle and take clears at the end.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			en_reg   <= RST_ENABLE[NUM_SRC-1:0];
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
			if (i_core.insn_end) begin
				en_reg <= en_shadow_next;
			end
		end
	end

	// Resolved requests take two cycles before they are forwarded.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pend_reg  <= '0;
			o_req_fwd <= '0;
		end else begin
			pend_reg  <= resolved;
			o_req_fwd <= pend_reg;
		end
	end

	// Fixed sources stay pending until taken; a new edge wins over the take.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			nmi_pend_reg  <= 1'b0;
			abrk_pend_reg <= 1'b0;
			nmi_seen_reg  <= 1'b0;
		end else begin
			nmi_seen_reg  <= nmi_level;
			nmi_pend_reg  <= nmi_rise || (nmi_pend_reg && !take_nmi);
			abrk_pend_reg <= i_abrk_req || (abrk_pend_reg && !take_abrk);
		end
	end

	// Byte moves report no transfer break, so only their end can be a boundary.
	// Word moves let only the non-maskable request break in; the return address
	// the core offers there already points past the move.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= IAC_ST_IDLE;
			o_accept  <= '0;
		end else begin
			state_reg       <= state_next;
			o_accept.valid  <= take_any;
			o_accept.is_nmi <= take_nmi;
			o_accept.ret_next <= take_nmi_brk;
			if (take_any) begin
				o_accept.vector <= take_vec;
				o_accept.ret_pc <= i_core.next_pc;
			end
		end
	end

	// The core raises the mask bit once stacking is done.
	// Raising it only after the stack write keeps the saved condition code unmasked,
	// so a return from the handler restores the mask state of the interrupted code.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_set_mask <= 1'b0;
		end else begin
			o_set_mask <= (state_reg == IAC_ST_STACK) && i_core.stack_done;
		end
	end

	// Event status: a read clears, but an event in the same cycle survives.
	// Letting the set win means a read can never swallow an event it did not report.
	// The last vector is kept for software that wants to see what was taken.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			evt_stat_reg <= '0;
			last_vec_reg <= '0;
		end else begin
			evt_stat_reg <= (rd_stat ? '0 : evt_stat_reg) | evt_set;
			if (take_any) begin
				last_vec_reg <= take_vec;
			end
		end
	end

	// Read data and interrupt line, both registered.
	// The line uses the next status value, so it follows a read clear without a lag cycle.
	// Read data are zero outside the answer cycle so a bus OR of several slaves stays clean.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0000_0000;
			o_irq   <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
			o_irq   <= |(((rd_stat ? '0 : evt_stat_reg) | evt_set) & evt_mask_reg);
		end
	end
endmodule : iac_top

// ### iac_top_sva.sv
`timescale 1ns/1ps
// Acceptance timing and read data checks on the ports of the top module.
module iac_top_sva
	import iac_pkg::*;
#(
	parameter int NUM_SRC = 8
) (
	input wire logic        i_sys_clk,
	input wire logic        i_nrst,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire iac_core_t   i_core,
	input wire iac_accept_t o_accept,
	input wire logic        o_set_mask
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	// An accept is one pulse; stacking completion leads to the mask set.
	sequence s_pulse;
		o_accept.valid ##1 !o_accept.valid;
	endsequence
	sequence s_stack;
		i_core.stack_done ##1 o_set_mask;
	endsequence
	chk_acc_boundary: assert property (o_accept.valid |-> $past(i_core.insn_end) || $past(i_core.xfer_break))
		else $error("accept away from a boundary");
	chk_acc_pulse: assert property (o_accept.valid |-> s_pulse)
		else $error("accept longer than one cycle");
	chk_mask_set: assert property (i_core.stack_done |-> s_stack)
		else $error("mask not set after stacking");
	chk_byte_hold: assert property (i_core.blk_byte_busy && !i_core.insn_end |=> !o_accept.valid)
		else $error("accept inside byte move");
	chk_word_hold: assert property (o_accept.valid && $past(i_core.blk_word_busy) && !$past(i_core.insn_end)
		|-> o_accept.is_nmi && o_accept.ret_next) else $error("maskable accept inside word move");
	chk_ret_addr: assert property (o_accept.valid && o_accept.ret_next |-> o_accept.ret_pc == $past(i_core.next_pc))
		else $error("wrong return address");
	chk_defer_next: assert property (i_core.insn_end && i_core.insn_cls == IAC_INSN_MASK_CHG |=> !o_accept.valid)
		else $error("accept right after mask change");
	chk_mask_hold: assert property (o_accept.valid && !o_accept.is_nmi && o_accept.vector != VEC_ABRK
		|-> !$past(i_core.ccr_mask)) else $error("maskable accept while masked");
	chk_nmi_vec: assert property (o_accept.valid && o_accept.is_nmi |-> o_accept.vector == VEC_NMI)
		else $error("wrong vector for non-maskable");
	chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside read answer");
endmodule : iac_top_sva
bind iac_top iac_top_sva #(.NUM_SRC(NUM_SRC)) u_sva (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_core(i_core), .o_accept(o_accept), .o_set_mask(o_set_mask));

// ### iac_core_model.sv
`timescale 1ns/1ps
// Behavioural core: one instruction per start pulse, stacking after every accept.
module iac_core_model
	import iac_pkg::*;
#(
	parameter logic [15:0] NEXT_PC = 16'h0a40
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_start,
	input  wire iac_insn_t   i_cls,
	input  wire logic [4:0]  i_len,
	input  wire logic        i_hold,
	input  wire logic        i_ccr_clr,
	input  wire iac_accept_t i_accept,
	input  wire logic        i_set_mask,
	output iac_core_t        o_core,
	output logic             o_busy
);
	logic [4:0] cnt_reg;
	logic [2:0] stk_reg;
	logic       ccr_reg;
	iac_insn_t  cls_reg;
	logic       run;
	logic       wmov;
	// Status follows the countdown; a count of one is the final cycle.
	assign run = cnt_reg != 5'h0;
	assign wmov = run && cls_reg == IAC_INSN_BLK_WORD;
	assign o_core.insn_end = cnt_reg == 5'h1;
	assign o_core.insn_cls = cls_reg;
	assign o_core.blk_word_busy = wmov;
	assign o_core.blk_byte_busy = run && cls_reg == IAC_INSN_BLK_BYTE;
	assign o_core.xfer_break = wmov && cnt_reg[0] && cnt_reg > 5'h2;
	assign o_core.stack_done = stk_reg == 3'h1;
	assign o_core.ccr_mask = ccr_reg | i_hold;
	assign o_core.next_pc = NEXT_PC;
	assign o_busy = run || stk_reg != 3'h0 || i_accept.valid;
	// A break accept abandons the move, since the move resumes by software retry.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 5'h0;
			stk_reg <= 3'h0;
			ccr_reg <= 1'b0;
			cls_reg <= IAC_INSN_PLAIN;
		end else begin
			if (i_start) begin
				cnt_reg <= i_len;
				cls_reg <= i_cls;
			end else if (i_accept.valid && i_accept.ret_next) begin
				cnt_reg <= 5'h0;
			end else if (run) begin
				cnt_reg <= cnt_reg - 5'h1;
			end
			stk_reg <= i_accept.valid ? 3'h3 : stk_reg - 3'(stk_reg != 3'h0);
			ccr_reg <= i_set_mask | (ccr_reg & !i_ccr_clr);
		end
	end
endmodule : iac_core_model

// ### iac_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t %s", $time, m); end end
// Acceptance scenarios driven through the register port and the core model.
module iac_top_tb_top;
	import iac_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  raise = 8'h00;
	logic        nmi = 1'b0;
	logic        abrk = 1'b0;
	logic        start = 1'b0;
	iac_insn_t   cls = IAC_INSN_PLAIN;
	logic [4:0]  len = 5'h0;
	logic        hold = 1'b0;
	logic        cclr = 1'b0;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic [7:0]  fwd;
	logic        busy;
	logic        set_mask;
	logic        irq;
	logic        irq_a;
	iac_core_t   core;
	iac_accept_t acc;
	iac_accept_t got;
	int          num_errors = 0;
	int          checks = 0;
	int          nacc;
	int          tacc;
	always #5 clk = ~clk;
	iac_top #(.NUM_SRC(8)) DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_src_raise(raise), .i_nmi_pin(nmi), .i_abrk_req(abrk), .i_core(core),
		.o_accept(acc), .o_req_fwd(fwd), .o_set_mask(set_mask), .o_irq(irq));
	iac_core_model u_core (.i_sys_clk(clk), .i_nrst(nrst), .i_start(start), .i_cls(cls), .i_len(len),
		.i_hold(hold), .i_ccr_clr(cclr), .i_accept(acc), .i_set_mask(set_mask), .o_core(core), .o_busy(busy));
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		rv = rdata;
	endtask : rreg
	task automatic rise(input int i);
		@(posedge clk);
		raise <= 8'h1 << i;
		@(posedge clk);
		raise <= 8'h0;
	endtask : rise
	// Runs one instruction, logs any accept, then unmasks as the handler would on return.
	task automatic step(input iac_insn_t c, input logic [4:0] n);
		@(posedge clk);
		start <= 1'b1;
		cls <= c;
		len <= n;
		@(posedge clk);
		start <= 1'b0;
		nacc = 0;
		for (int k = 0; k < 80 && (k < 2 || busy); k++) begin
			@(negedge clk);
			if (acc.valid === 1'b1) begin
				nacc++;
				tacc = k;
				got = acc;
			end
		end
		repeat (3) @(posedge clk);
		cclr <= 1'b1;
		@(posedge clk);
		cclr <= 1'b0;
	endtask : step
	task automatic ck(input int n, input logic [5:0] v, input string m);
		`CHK(nacc, n, m)
		if (n > 0) `CHK(got.vector, v, m)
	endtask : ck
	// Register writes reach acceptance only at an instruction end, so a masked instruction commits them.
	task automatic commit;
		logic h;
		h = hold;
		hold <= 1'b1;
		step(IAC_INSN_PLAIN, 5'h2);
		hold <= h;
	endtask : commit
	// Flags stay set after an accept; the clear is committed with the core masked.
	task automatic clr(input int i);
		wreg(OFF_FLAG, ~(32'h1 << i));
		commit();
	endtask : clr
	task automatic race(input int i, input logic [7:0] a);
		fork
			step(IAC_INSN_PLAIN, 5'd12);
			begin
				repeat (3) @(posedge clk);
				rise(i);
				wreg(a, ~(32'h1 << i));
			end
		join
	endtask : race
	task automatic move(input iac_insn_t c);
		fork
			step(c, 5'd16);
			begin
				repeat (4) @(posedge clk);
				nmi <= 1'b1;
			end
		join
		nmi <= 1'b0;
	endtask : move
	task automatic final_report;
		$display("num_errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		#100us;
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rreg(OFF_ENABLE);
		`CHK(rv, RST_ENABLE, "enable reset")
		rreg(OFF_LEVEL);
		`CHK(rv, RST_LEVEL, "level reset")
		rreg(OFF_MODE);
		`CHK(rv[1:0], RST_MODE, "mode reset")
		rreg(OFF_EVT_MASK);
		`CHK(rv[3:0], RST_EVT_MASK, "event mask reset")
		rreg(8'hfc);
		`CHK(rv, 32'h0, "unmapped read")
		wreg(OFF_ENABLE, 32'hff);
		commit();
		rise(2);
		step(IAC_INSN_PLAIN, 5'h4);
		ck(1, VEC_PERIPH + 6'h2, "plain accept");
		clr(2);
		for (int k = 0; k < 2; k++) begin
			race(5 + k, k ? OFF_FLAG : OFF_ENABLE);
			ck(1, VEC_PERIPH + 6'(5 + k), "late clear race");
			clr(5 + k);
			wreg(OFF_ENABLE, 32'hff);
		end
		rise(0);
		race(5, OFF_ENABLE);
		ck(1, VEC_PERIPH, "higher priority wins");
		rreg(OFF_EVT_STAT);
		`CHK(rv[EVT_DISCARD], 1'b1, "discard event")
		clr(0);
		clr(5);
		wreg(OFF_ENABLE, 32'hff);
		hold <= 1'b1;
		race(4, OFF_ENABLE);
		ck(0, VEC_NMI, "masked clear");
		clr(4);
		wreg(OFF_ENABLE, 32'hff);
		rise(1);
		@(posedge clk);
		abrk <= 1'b1;
		@(posedge clk);
		abrk <= 1'b0;
		step(IAC_INSN_PLAIN, 5'h4);
		ck(1, VEC_ABRK, "break passes mask");
		nmi <= 1'b1;
		repeat (6) @(posedge clk);
		step(IAC_INSN_PLAIN, 5'h4);
		ck(1, VEC_NMI, "nmi passes mask");
		nmi <= 1'b0;
		hold <= 1'b0;
		step(IAC_INSN_PLAIN, 5'h4);
		ck(1, VEC_PERIPH + 6'h1, "pending after unmask");
		clr(1);
		rise(3);
		step(IAC_INSN_MASK_CHG, 5'h3);
		ck(0, VEC_NMI, "mask change defers");
		step(IAC_INSN_PLAIN, 5'h3);
		ck(1, VEC_PERIPH + 6'h3, "taken after next");
		clr(3);
		move(IAC_INSN_BLK_BYTE);
		ck(1, VEC_NMI, "nmi after byte move");
		`CHK(tacc, 16, "byte move not held")
		rise(7);
		step(IAC_INSN_BLK_WORD, 5'd16);
		ck(1, VEC_PERIPH + 6'h7, "maskable after word move");
		`CHK(tacc, 16, "word move not held")
		clr(7);
		move(IAC_INSN_BLK_WORD);
		ck(1, VEC_NMI, "nmi in word move");
		`CHK(tacc < 15, 1'b1, "nmi waited for move end")
		`CHK(got.ret_next, 1'b1, "break flag")
		`CHK(got.ret_pc, 16'h0a40, "return address")
		step(IAC_INSN_BLK_WORD, 5'h8);
		ck(0, VEC_NMI, "retried move interrupted");
		wreg(OFF_EVT_MASK, 32'h0);
		rise(2);
		step(IAC_INSN_PLAIN, 5'h4);
		clr(2);
		@(negedge clk);
		irq_a = irq;
		wreg(OFF_EVT_MASK, 32'hf);
		repeat (2) @(negedge clk);
		`CHK(irq !== irq_a, 1'b1, "irq ignores mask")
		rreg(OFF_EVT_STAT);
		`CHK(rv[EVT_ACCEPT], 1'b1, "accept event")
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0, "irq after status read")
		final_report();
	end
endmodule : iac_top_tb_top
